// file: rtl/tfthif_pkg.sv
// Shared constants and types for the display host interface front end
package tfthif_pkg;
    // ==========================================
    // Panel geometry and bus widths
    localparam int H_PIXELS = 240;
    localparam int V_LINES = 320;
    localparam int LANE_W = 18;
    localparam int X_W = 8;
    localparam int Y_W = 9;
    localparam int SER_BITS = 8;
    localparam logic [2:0] SER_LAST = 3'h7;
    localparam logic [X_W-1:0] X_LAST = X_W'(H_PIXELS - 1);
    localparam logic [Y_W-1:0] Y_LAST = Y_W'(V_LINES - 1);
    localparam logic [X_W-1:0] X_ZERO = 8'h00;
    localparam logic [Y_W-1:0] Y_ZERO = 9'h000;
    localparam logic [LANE_W-1:0] LANES_ZERO = 18'h0_0000;
    // ==========================================
    // Interface mode strap codes
    typedef enum logic [2:0] {
        MODE_PAR8 = 3'b000,
        MODE_PAR16 = 3'b001,
        MODE_PAR9 = 3'b010,
        MODE_PAR18 = 3'b011,
        MODE_OFF = 3'b100,
        MODE_SER3 = 3'b101,
        MODE_SER4 = 3'b110,
        MODE_SPARE = 3'b111
    } tfthif_mode_type;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_DCBIT = 2'b01,
        SER_DATA = 2'b10
    } tfthif_ser_type;
    // ==========================================
    // Carriers
    typedef struct packed {
        logic is_data;
        logic [LANE_W-1:0] value;
    } tfthif_word_type;
    typedef struct packed {
        logic [X_W-1:0] x;
        logic [Y_W-1:0] y;
        logic [LANE_W-1:0] rgb;
    } tfthif_pixel_type;
endpackage : tfthif_pkg

// file: rtl/tfthif_front_end.sv
// Host interface front end: parallel MCU bus, serial link and RGB video port
module tfthif_front_end (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pixel_clock,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic data_command_select,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic interface_mode_select_bit0,
    input wire logic interface_mode_select_bit1,
    input wire logic interface_mode_select_bit2,
    input wire logic lane_select_strap,
    input wire logic rgb_port_select,
    input wire logic colour_depth_18,
    input wire logic [tfthif_pkg::LANE_W-1:0] parallel_data_lanes_in,
    output logic [tfthif_pkg::LANE_W-1:0] parallel_data_lanes_out,
    output logic parallel_data_lanes_oe,
    input wire logic serial_data_in,
    output logic serial_data_io_out,
    output logic serial_data_io_oe,
    output logic serial_data_out,
    input wire logic serial_read_enable,
    input wire logic vertical_sync_n,
    input wire logic horizontal_sync_n,
    input wire logic data_enable,
    input wire logic [tfthif_pkg::LANE_W-1:0] read_data,
    output tfthif_pkg::tfthif_word_type host_word,
    output logic host_word_valid,
    output logic host_read_done,
    output tfthif_pkg::tfthif_pixel_type pixel,
    output logic pixel_valid,
    output logic frame_start
);
    import tfthif_pkg::*;

    // ==========================================
    // Pin synchronisers
    localparam int PIN_W = LANE_W + 11;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_s;
    wire [PIN_W-1:0] pin_raw = {parallel_data_lanes_in, reset_n, chip_select_n, data_command_select,
        write_strobe_n, read_strobe_n, serial_data_in, interface_mode_select_bit2,
        interface_mode_select_bit1, interface_mode_select_bit0, lane_select_strap, rgb_port_select};
    always_ff @(posedge sys_clk) begin
        pin_meta <= pin_raw;
        pin_s <= pin_meta;
    end
    wire [LANE_W-1:0] lanes_s = pin_s[PIN_W-1:11];
    wire reset_n_s = pin_s[10];
    wire cs_s = pin_s[9];
    wire dc_s = pin_s[8];
    wire wr_s = pin_s[7];
    wire rd_s = pin_s[6];
    wire sda_s = pin_s[5];
    wire [2:0] mode_bits = pin_s[4:2];
    wire lane_sel = pin_s[1];
    wire rgb_sel = pin_s[0];

    logic dev_rst;
    always_ff @(posedge sys_clk) begin
        dev_rst <= rst | ~reset_n_s;
    end

    // ==========================================
    // Mode decode
    // Strap decode
    wire tfthif_mode_type mode = tfthif_mode_type'(mode_bits);
    wire is_parallel = ~mode_bits[2];
    wire is_serial = (mode == MODE_SER3) | (mode == MODE_SER4);
    wire rgb_allowed = is_serial & rgb_sel;

    function automatic logic [LANE_W-1:0] gather(input tfthif_mode_type m, input logic ls,
        input logic [LANE_W-1:0] l);
        case (m)
            MODE_PAR8: gather = ls ? {10'h000, l[17:10]} : {10'h000, l[7:0]};
            MODE_PAR9: gather = ls ? {9'h000, l[17:9]} : {9'h000, l[8:0]};
            MODE_PAR16: gather = ls ? {2'h0, l[17:10], l[8:1]} : {2'h0, l[15:0]};
            MODE_PAR18: gather = l;
            default: gather = LANES_ZERO;
        endcase
    endfunction : gather

    function automatic logic [LANE_W-1:0] scatter(input tfthif_mode_type m, input logic ls,
        input logic [LANE_W-1:0] d);
        case (m)
            MODE_PAR8: scatter = ls ? {d[7:0], 10'h000} : {10'h000, d[7:0]};
            MODE_PAR9: scatter = ls ? {d[8:0], 9'h000} : {9'h000, d[8:0]};
            MODE_PAR16: scatter = ls ? {d[15:8], 1'b0, d[7:0], 1'b0} : {2'h0, d[15:0]};
            MODE_PAR18: scatter = d;
            default: scatter = LANES_ZERO;
        endcase
    endfunction : scatter

    // ==========================================
    // Parallel MCU bus
    logic wr_prev;
    logic rd_prev;
    always_ff @(posedge sys_clk) begin
        wr_prev <= wr_s;
        rd_prev <= rd_s;
    end
    wire cs_on = ~cs_s;
    wire par_wr = is_parallel & cs_on & wr_s & ~wr_prev;
    wire par_rd = is_parallel & cs_on & ~rd_s;
    wire par_rd_end = is_parallel & cs_on & rd_s & ~rd_prev;
    wire [LANE_W-1:0] par_value = gather(mode, lane_sel, lanes_s);

    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            parallel_data_lanes_oe <= 1'b0;
            parallel_data_lanes_out <= LANES_ZERO;
            host_read_done <= 1'b0;
        end else begin
            parallel_data_lanes_oe <= par_rd;
            parallel_data_lanes_out <= scatter(mode, lane_sel, read_data);
            host_read_done <= par_rd_end;
        end
    end

    // ==========================================
    // Serial link
    // Flag pin clocks serial
    logic sclk_prev;
    always_ff @(posedge sys_clk) begin
        sclk_prev <= dc_s;
    end
    wire ser_rise = dc_s & ~sclk_prev;
    wire ser_fall = ~dc_s & sclk_prev;
    tfthif_ser_type ser_state;
    tfthif_ser_type next_ser_state;
    logic [2:0] bit_count;
    logic [SER_BITS-1:0] shift_in;
    logic [SER_BITS-1:0] shift_out;
    logic ser_dc;
    wire ser_active = is_serial & cs_on;
    wire ser_last = (ser_state == SER_DATA) & ser_rise & (bit_count == SER_LAST);
    wire ser_flag = (mode == MODE_SER4) ? wr_s : ser_dc;
    wire tfthif_ser_type ser_entry = (mode == MODE_SER3) ? SER_DCBIT : SER_DATA;

    always_comb begin
        next_ser_state = ser_state;
        case (ser_state)
            SER_IDLE: if (ser_active) next_ser_state = ser_entry;
            SER_DCBIT: if (ser_rise) next_ser_state = SER_DATA;
            SER_DATA: if (ser_last) next_ser_state = ser_entry;
            default: next_ser_state = SER_IDLE;
        endcase
        if (!ser_active) next_ser_state = SER_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            ser_state <= SER_IDLE;
            bit_count <= 3'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            ser_dc <= 1'b0;
        end else begin
            ser_state <= next_ser_state;
            if (ser_state == SER_IDLE) begin
                bit_count <= 3'h0;
                shift_out <= read_data[SER_BITS-1:0];
            end
            if ((ser_state == SER_DCBIT) && ser_rise) ser_dc <= sda_s;
            if ((ser_state == SER_DATA) && ser_rise) begin
                shift_in <= {shift_in[SER_BITS-2:0], sda_s};
                bit_count <= bit_count + 3'h1;
            end
            if ((ser_state == SER_DATA) && ser_fall) shift_out <= {shift_out[SER_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            serial_data_out <= 1'b0;
            serial_data_io_out <= 1'b0;
            serial_data_io_oe <= 1'b0;
        end else begin
            serial_data_out <= ser_active & shift_out[SER_BITS-1];
            serial_data_io_out <= shift_out[SER_BITS-1];
            serial_data_io_oe <= ser_active & (mode == MODE_SER3) & serial_read_enable;
        end
    end

    // ==========================================
    // Word output
    // Flag latched with word
    wire tfthif_word_type par_word = '{is_data: dc_s, value: par_value};
    wire tfthif_word_type ser_word = '{is_data: ser_flag, value: {10'h000, shift_in[SER_BITS-2:0], sda_s}};
    always_ff @(posedge sys_clk) begin
        if (dev_rst) begin
            host_word <= '0;
            host_word_valid <= 1'b0;
        end else begin
            host_word_valid <= par_wr | ser_last;
            if (par_wr) host_word <= par_word;
            else if (ser_last) host_word <= ser_word;
        end
    end

    // ==========================================
    // RGB port on the pixel clock
    logic [1:0] prst_sync;
    logic [1:0] prgb_sync;
    logic [1:0] pdepth_sync;
    always_ff @(posedge pixel_clock) begin
        prst_sync <= {prst_sync[0], dev_rst};
        prgb_sync <= {prgb_sync[0], rgb_allowed};
        pdepth_sync <= {pdepth_sync[0], colour_depth_18};
    end
    wire prst = prst_sync[1];
    wire rgb_on = prgb_sync[1];
    wire [15:0] rgb16 = {parallel_data_lanes_in[17:13], parallel_data_lanes_in[11:1]};
    wire [LANE_W-1:0] rgb16x = {rgb16[15:11], rgb16[15], rgb16[10:5], rgb16[4:0], rgb16[4]};
    wire [LANE_W-1:0] rgb_word = pdepth_sync[1] ? parallel_data_lanes_in : rgb16x;
    logic [X_W-1:0] px;
    logic [Y_W-1:0] py;
    logic hs_prev;
    logic vs_prev;
    logic frame_tog;
    wire line_edge = hs_prev & ~horizontal_sync_n;
    wire frame_edge = vs_prev & ~vertical_sync_n;
    wire take_pix = rgb_on & data_enable & horizontal_sync_n & vertical_sync_n;

    always_ff @(posedge pixel_clock) begin
        if (prst) begin
            px <= X_ZERO;
            py <= Y_ZERO;
            hs_prev <= 1'b1;
            vs_prev <= 1'b1;
            frame_tog <= 1'b0;
            pixel <= '0;
            pixel_valid <= 1'b0;
        end else begin
            hs_prev <= horizontal_sync_n;
            vs_prev <= vertical_sync_n;
            pixel_valid <= take_pix;
            if (take_pix) begin
                pixel <= '{x: px, y: py, rgb: rgb_word};
                if (px != X_LAST) px <= px + 8'h01;
            end
            if (!horizontal_sync_n) px <= X_ZERO;
            if (line_edge && py != Y_LAST) py <= py + 9'h001;
            if (!vertical_sync_n) begin
                px <= X_ZERO;
                py <= Y_ZERO;
            end
            if (frame_edge && rgb_on) frame_tog <= ~frame_tog;
        end
    end

    // Frame start toggle into the system clock
    logic [2:0] ftog_sync;
    always_ff @(posedge sys_clk) begin
        ftog_sync <= {ftog_sync[1:0], frame_tog};
    end
    always_ff @(posedge sys_clk) begin
        if (dev_rst) frame_start <= 1'b0;
        else frame_start <= ftog_sync[2] ^ ftog_sync[1];
    end

    // ==========================================
    // Checks
    sequence ser_byte_end_s;
        ser_state == SER_DATA ##0 ser_rise ##0 bit_count == SER_LAST;
    endsequence
    sequence par_write_s;
        is_parallel ##0 cs_on ##0 wr_s ##0 !wr_prev;
    endsequence

    cs_gate_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        host_word_valid |-> $past(cs_on))
        else $error("Word accepted with chip select high");
    dc_tag_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        par_write_s |=> host_word_valid && host_word.is_data == $past(dc_s))
        else $error("Written word lost its data/command flag");
    lane8_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        par_write_s ##0 (mode == MODE_PAR8 && lane_sel)
        |=> host_word.value == {10'h000, $past(lanes_s[17:10])})
        else $error("8-bit upper lane word wrong");
    read_drive_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        par_rd |=> parallel_data_lanes_oe ##1 (parallel_data_lanes_oe || rd_prev))
        else $error("Lanes not driven during read");
    serial_quiet_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        !is_parallel |=> !parallel_data_lanes_oe)
        else $error("Lanes driven outside parallel mode");
    ser_word_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        ser_byte_end_s |=> host_word_valid && host_word.value[0] == $past(sda_s))
        else $error("Serial byte not delivered");
    sdo_idle_a: assert property (@(posedge sys_clk) disable iff (dev_rst)
        !ser_active |=> !serial_data_out && !serial_data_io_oe)
        else $error("Serial output driven while idle");
    pix_gate_a: assert property (@(posedge pixel_clock) disable iff (prst)
        pixel_valid |-> $past(data_enable) && $past(rgb_on))
        else $error("Pixel captured without enable");
    line_start_a: assert property (@(posedge pixel_clock) disable iff (prst)
        !horizontal_sync_n ##1 take_pix |=> pixel.x == X_ZERO)
        else $error("Line did not restart at column zero");
    frame_start_a: assert property (@(posedge pixel_clock) disable iff (prst)
        !vertical_sync_n ##1 take_pix |=> pixel.y == Y_ZERO)
        else $error("Frame did not restart at line zero");
endmodule : tfthif_front_end

// file: bench/tfthif_host_model.sv
// Host model that drives the display front end pins
module tfthif_host_model (
    input wire logic sys_clk,
    input wire logic serial_data_out,
    input wire logic [17:0] dut_lanes,
    input wire logic dut_oe,
    output logic pixel_clock = 1'b0,
    output logic chip_select_n = 1'b1,
    output logic data_command_select = 1'b0,
    output logic write_strobe_n = 1'b1,
    output logic read_strobe_n = 1'b1,
    output logic [17:0] lanes = 18'h0_0000,
    output logic serial_data_in = 1'b0,
    output logic vertical_sync_n = 1'b1,
    output logic horizontal_sync_n = 1'b1,
    output logic data_enable = 1'b0,
    output logic [17:0] rd_got = 18'h0_0000,
    output logic [7:0] sdo_byte = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Clocks and pacing
    initial forever #6 pixel_clock = ~pixel_clock;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic ptick(input int n);
        repeat (n) @(posedge pixel_clock);
        #1;
    endtask : ptick
    // ==========================================
    // Parallel bus
    // word held across strobe
    task automatic par_write(input logic cs_n, input logic dc, input logic [17:0] v);
        tick(1);
        chip_select_n = cs_n;
        data_command_select = dc;
        lanes = v;
        write_strobe_n = 1'b0;
        tick(4);
        write_strobe_n = 1'b1;
        tick(3);
        chip_select_n = 1'b1;
        lanes = ~v;
        tick(3);
    endtask : par_write
    task automatic par_read();
        tick(1);
        chip_select_n = 1'b0;
        read_strobe_n = 1'b0;
        lanes = ~lanes;
        tick(6);
        rd_got = dut_oe ? dut_lanes : 18'h0_0000;
        read_strobe_n = 1'b1;
        tick(4);
        chip_select_n = 1'b1;
        tick(2);
    endtask : par_read
    // ==========================================
    // Serial link
    // flag pin clocks bits
    task automatic ser_send(input logic wire3, input logic flag, input logic [7:0] b, input int n);
        logic [8:0] bits;
        bits = wire3 ? {flag, b} : {b, 1'b0};
        tick(1);
        data_command_select = 1'b0;
        write_strobe_n = flag;
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_in = bits[8-i];
            tick(6);
            sdo_byte = {sdo_byte[6:0], serial_data_out};
            data_command_select = 1'b1;
            tick(6);
            data_command_select = 1'b0;
            serial_data_in = ~serial_data_in;
        end
        tick(6);
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        tick(4);
    endtask : ser_send
    // ==========================================
    // Video port
    // syncs then pixels
    task automatic rgb_line(input logic vs, input int n, input logic de, input logic [17:0] base,
        input logic [17:0] step);
        ptick(1);
        vertical_sync_n = ~vs;
        ptick(4);
        horizontal_sync_n = 1'b0;
        ptick(4);
        // Line pulse ends inside a frame pulse when vs is set, else four ticks later; pixels follow the last sync at once
        horizontal_sync_n = vs;
        ptick(4);
        horizontal_sync_n = 1'b1;
        vertical_sync_n = 1'b1;
        for (int i = 0; i < n; i++) begin
            data_enable = de;
            lanes = base ^ (18'(i) * step);
            ptick(1);
        end
        data_enable = 1'b0;
        lanes = ~lanes;
        ptick(4);
    endtask : rgb_line
endmodule : tfthif_host_model

// file: bench/tfthif_front_end_bench.sv
// Self-checking bench for the display host interface front end
module tfthif_front_end_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import tfthif_pkg::*;
    `define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
    typedef struct packed {
        tfthif_mode_type m;
        logic ls;
    } tfthif_row_type;
    localparam logic [17:0] PAT = 18'h2_D2B4;
    tfthif_row_type rows [8] = '{'{MODE_PAR8, 1'b0}, '{MODE_PAR8, 1'b1}, '{MODE_PAR9, 1'b0}, '{MODE_PAR9, 1'b1},
        '{MODE_PAR16, 1'b0}, '{MODE_PAR16, 1'b1}, '{MODE_PAR18, 1'b0}, '{MODE_PAR18, 1'b1}};
    logic sys_clk, rst = 1'b1, reset_n = 1'b1, lane_select_strap = 1'b0, rgb_port_select = 1'b0;
    logic colour_depth_18 = 1'b1, serial_read_enable = 1'b0;
    tfthif_mode_type mode = MODE_PAR8;
    logic [17:0] read_data = 18'h1_2AC6, host_lanes, parallel_data_lanes_out, rd_got;
    logic parallel_data_lanes_oe, host_sdi, serial_data_io_out, serial_data_io_oe, serial_data_out, pixel_clock;
    logic chip_select_n, data_command_select, write_strobe_n, read_strobe_n, vertical_sync_n, horizontal_sync_n;
    logic data_enable, host_word_valid, host_read_done, pixel_valid, frame_start;
    logic [7:0] sdo_byte;
    tfthif_word_type host_word;
    tfthif_pixel_type pixel;
    tfthif_pixel_type pq[$];
    int n_fail = 0, tests_run = 0, n_words = 0, n_done = 0, n_frames = 0, n_drive = 0, cycles = 0, w;
    // ==========================================
    // Wiring, clock and monitors
    tfthif_front_end tfthif_front_end_inst (.sys_clk, .rst, .pixel_clock, .reset_n, .chip_select_n,
        .data_command_select, .write_strobe_n, .read_strobe_n, .interface_mode_select_bit0(mode[0]),
        .interface_mode_select_bit1(mode[1]), .interface_mode_select_bit2(mode[2]), .lane_select_strap,
        .rgb_port_select, .colour_depth_18, .parallel_data_lanes_in(parallel_data_lanes_oe ? parallel_data_lanes_out : host_lanes),
        .parallel_data_lanes_out, .parallel_data_lanes_oe,
        .serial_data_in(serial_data_io_oe ? serial_data_io_out : host_sdi), .serial_data_io_out, .serial_data_io_oe,
        .serial_data_out, .serial_read_enable, .vertical_sync_n, .horizontal_sync_n, .data_enable, .read_data,
        .host_word, .host_word_valid, .host_read_done, .pixel, .pixel_valid, .frame_start);
    tfthif_host_model hm (.sys_clk, .serial_data_out, .dut_lanes(parallel_data_lanes_out),
        .dut_oe(parallel_data_lanes_oe), .pixel_clock, .chip_select_n, .data_command_select, .write_strobe_n,
        .read_strobe_n, .lanes(host_lanes), .serial_data_in(host_sdi), .vertical_sync_n, .horizontal_sync_n,
        .data_enable, .rd_got, .sdo_byte);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        n_words += int'(host_word_valid === 1'b1);
        n_done += int'(host_read_done === 1'b1);
        n_frames += int'(frame_start === 1'b1);
        n_drive += int'(serial_data_io_oe === 1'b1 && serial_data_io_out === read_data[7]);
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    always @(negedge pixel_clock) begin
        if (pixel_valid === 1'b1) pq.push_back(pixel);
    end
    // Active lanes of a bus width, packed low
    function automatic logic [17:0] pick(input tfthif_mode_type m, input logic ls, input logic [17:0] v);
        case (m)
            MODE_PAR8: return ls ? {10'h000, v[17:10]} : {10'h000, v[7:0]};
            MODE_PAR9: return ls ? {9'h000, v[17:9]} : {9'h000, v[8:0]};
            MODE_PAR16: return ls ? {2'h0, v[17:10], v[8:1]} : {2'h0, v[15:0]};
            default: return v;
        endcase
    endfunction : pick
    task end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // ==========================================
    // Tests
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        hm.tick(6);
        foreach (rows[i]) begin
            mode = rows[i].m;
            lane_select_strap = rows[i].ls;
            w = n_words;
            hm.par_write(1'b0, i[0], PAT);
            `CHECK("words", w + 1, n_words)
            `CHECK("value", pick(rows[i].m, rows[i].ls, PAT), host_word.value)
            `CHECK("flag", i[0], host_word.is_data)
            w = n_done;
            hm.par_read();
            `CHECK("done", w + 1, n_done)
            `CHECK("rd", read_data & pick(mode, lane_select_strap, 18'h3_FFFF), pick(mode, lane_select_strap, rd_got))
            $display("row %0d done", i);
        end
        reset_n = 1'b0;
        hm.tick(6);
        `CHECK("pin reset", 19'h0_0000, host_word)
        reset_n = 1'b1;
        hm.tick(6);
        w = n_words;
        hm.par_write(1'b1, 1'b1, PAT);
        `CHECK("cs high", w, n_words)
        mode = MODE_SER3;
        hm.par_write(1'b0, 1'b1, PAT);
        hm.par_read();
        `CHECK("par in serial", w, n_words)
        `CHECK("read in serial", 18'h0_0000, rd_got)
        hm.ser_send(1'b1, 1'b1, 8'hA5, 9);
        `CHECK("3-wire", 9'h1A5, {host_word.is_data, host_word.value[7:0]})
        serial_read_enable = 1'b1;
        w = n_drive;
        hm.ser_send(1'b1, 1'b1, 8'h00, 0);
        serial_read_enable = 1'b0;
        `CHECK("sda drive", w + 6, n_drive)
        mode = MODE_SER4;
        hm.ser_send(1'b0, 1'b0, 8'h5A, 8);
        `CHECK("4-wire", 9'h05A, {host_word.is_data, host_word.value[7:0]})
        `CHECK("read-back", read_data[7:0], sdo_byte)
        w = n_words;
        hm.ser_send(1'b0, 1'b1, 8'hFF, 4);
        hm.ser_send(1'b0, 1'b1, 8'h81, 8);
        `CHECK("abort", w + 1, n_words)
        `CHECK("after abort", 9'h181, {host_word.is_data, host_word.value[7:0]})
        $display("serial done");
        rgb_port_select = 1'b1;
        hm.tick(4);
        w = n_frames;
        hm.rgb_line(1'b1, 242, 1'b1, PAT, 18'h0_0001);
        hm.tick(4);
        `CHECK("frame", w + 1, n_frames)
        `CHECK("pixels", 242, pq.size())
        foreach (pq[i]) begin
            `CHECK("x", X_W'((i > 239) ? 239 : i), pq[i].x)
            `CHECK("y", 9'h000, pq[i].y)
            `CHECK("rgb", PAT ^ 18'(i), pq[i].rgb)
        end
        pq.delete();
        colour_depth_18 = 1'b0;
        hm.rgb_line(1'b0, 3, 1'b0, PAT, 18'h0_0001);
        `CHECK("no enable", 0, pq.size())
        hm.rgb_line(1'b0, 2, 1'b1, PAT, 18'h0_1001);
        `CHECK("pair", 2, pq.size())
        `CHECK("line count", 9'h002, pq[0].y)
        `CHECK("unused lanes", pq[0].rgb, pq[1].rgb)
        `CHECK("rgb16", {PAT[17:13], PAT[17], PAT[11:6], PAT[5:1], PAT[5]}, pq[0].rgb)
        pq.delete();
        mode = MODE_PAR8;
        hm.tick(4);
        hm.rgb_line(1'b0, 2, 1'b1, PAT, 18'h0_0001);
        `CHECK("rgb in parallel", 0, pq.size())
        $display("video done");
        end_sim();
    end
endmodule : tfthif_front_end_bench
